/* File: logic/cpwm_timer.sv */
// complementary pwm timer: two coupled 16-bit counters, three pwm pairs
// assumes synchronous strobe register port, outputs to bridge gate drivers
module cpwm_timer (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire cpwm_pkg::cpwm_bus_req_type bus_req,
	output logic [cpwm_pkg::DATA_W-1:0] rdata,
	output logic irq,
	output cpwm_pkg::cpwm_pins_type pwm_pins,
	output cpwm_pkg::cpwm_pins_type pwm_oe,
	output logic carrier_toggle_pin
);

	// software registers
	logic [7:0] ch3_count_control;
	logic [7:0] ch4_count_control;
	logic [7:0] ch3_mode;
	logic [7:0] ch4_mode;
	logic [7:0] ch3_irq_enable;
	logic [7:0] output_master_enable;
	logic [7:0] output_control_1;
	logic [7:0] output_control_2;
	logic [7:0] counter_start;
	logic [15:0] ch3_counter;
	logic [15:0] ch4_counter;
	logic [15:0] half_period;
	logic [15:0] dead_time;
	logic [15:0] ch3_general_a;
	logic [15:0] ch3_general_b;
	logic [15:0] ch4_general_a;
	logic [15:0] ch4_general_b;
	logic [15:0] half_period_buffer;
	logic [15:0] ch3_general_c;
	logic [15:0] ch3_general_d;
	logic [15:0] ch4_general_c;
	logic [15:0] ch4_general_d;
	logic compare_a_flag;
	logic count_down;
	logic transfer_armed;
	logic [5:0] prescale_count [2];
	logic [1:0] tick;
	cpwm_pkg::cpwm_pins_type pin_level;

	// write decode
	wire wr = bus_req.wr;
	wire [31:0] wa = bus_req.addr;
	wire [15:0] wd = bus_req.wdata;
	wire w_cc3 = wr && wa == cpwm_pkg::ch3_count_control_addr;
	wire w_cc4 = wr && wa == cpwm_pkg::ch4_count_control_addr;
	wire w_md3 = wr && wa == cpwm_pkg::ch3_mode_addr;
	wire w_md4 = wr && wa == cpwm_pkg::ch4_mode_addr;
	wire w_ie3 = wr && wa == cpwm_pkg::ch3_irq_enable_addr;
	wire w_oe = wr && wa == cpwm_pkg::output_master_enable_addr;
	wire w_oc1 = wr && wa == cpwm_pkg::output_control_1_addr;
	wire w_oc2 = wr && wa == cpwm_pkg::output_control_2_addr;
	wire w_cnt3 = wr && wa == cpwm_pkg::ch3_counter_addr;
	wire w_cnt4 = wr && wa == cpwm_pkg::ch4_counter_addr;
	wire w_hp = wr && wa == cpwm_pkg::half_period_addr;
	wire w_dt = wr && wa == cpwm_pkg::dead_time_addr;
	wire w_ga3 = wr && wa == cpwm_pkg::ch3_general_a_addr;
	wire w_gb3 = wr && wa == cpwm_pkg::ch3_general_b_addr;
	wire w_ga4 = wr && wa == cpwm_pkg::ch4_general_a_addr;
	wire w_gb4 = wr && wa == cpwm_pkg::ch4_general_b_addr;
	wire w_hpb = wr && wa == cpwm_pkg::half_period_buffer_addr;
	wire w_gc3 = wr && wa == cpwm_pkg::ch3_general_c_addr;
	wire w_gd3 = wr && wa == cpwm_pkg::ch3_general_d_addr;
	wire w_gc4 = wr && wa == cpwm_pkg::ch4_general_c_addr;
	wire w_gd4 = wr && wa == cpwm_pkg::ch4_general_d_addr;
	wire w_st = wr && wa == cpwm_pkg::ch3_status_addr;
	wire w_start = wr && wa == cpwm_pkg::counter_start_addr;

	// mode decode; channel 4 mode register plays no part here
	wire [3:0] mode3 = ch3_mode[3:0];
	wire comp_mode = mode3 == cpwm_pkg::MODE_COMP_CREST ||
		mode3 == cpwm_pkg::MODE_COMP_TROUGH ||
		mode3 == cpwm_pkg::MODE_COMP_BOTH;
	wire xfer_at_crest = mode3 == cpwm_pkg::MODE_COMP_CREST ||
		mode3 == cpwm_pkg::MODE_COMP_BOTH;
	wire xfer_at_trough = mode3 == cpwm_pkg::MODE_COMP_TROUGH ||
		mode3 == cpwm_pkg::MODE_COMP_BOTH;
	wire start3 = counter_start[cpwm_pkg::START3_BIT];
	wire start4 = counter_start[cpwm_pkg::START4_BIT];
	wire comp_run = comp_mode && start3 && start4;
	wire run3 = comp_mode ? comp_run : start3;
	wire run4 = comp_mode ? comp_run : start4;

	// count clock choice per channel; ch4 borrows ch3 settings in comp mode
	wire [7:0] cc_eff [2];
	assign cc_eff[0] = ch3_count_control;
	assign cc_eff[1] = comp_mode ? ch3_count_control : ch4_count_control;
	wire [1:0] run_ch = {run4, run3};

	// prescaler per channel, tick is one rising count-clock edge
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++) begin : g_psc
			wire [2:0] psc = cc_eff[ch][cpwm_pkg::PSC_LSB +: 3];
			wire [1:0] edge_sel = cc_eff[ch][cpwm_pkg::EDGE_LSB +: 2];
			wire [5:0] last =
				psc == cpwm_pkg::PSC_DIV4 ? cpwm_pkg::DIV4_LAST :
				psc == cpwm_pkg::PSC_DIV16 ? cpwm_pkg::DIV16_LAST :
				psc == cpwm_pkg::PSC_DIV64 ? cpwm_pkg::DIV64_LAST :
				cpwm_pkg::DIV1_LAST;
			// other edge codes also use the rising edge of the clock
			wire rising = edge_sel == cpwm_pkg::EDGE_RISE ||
				edge_sel != cpwm_pkg::EDGE_RISE;
			assign tick[ch] = run_ch[ch] && rising &&
				prescale_count[ch] == last;
			always_ff @(posedge clk_sys or negedge rstn) begin
				if (!rstn) begin
					prescale_count[ch] <= 6'h00;
				end else if (!run_ch[ch] || prescale_count[ch] == last) begin
					prescale_count[ch] <= 6'h00;
				end else begin
					prescale_count[ch] <= prescale_count[ch] + 6'h01;
				end
			end
		end
	endgenerate

	// crest and trough of the triangle, ch3 runs dead time above ch4
	wire at_crest = !count_down && (ch3_counter == ch3_general_a ||
		ch4_counter == half_period);
	wire at_trough = count_down && ch3_counter == dead_time;
	wire comp_tick = comp_run && tick[0];
	wire crest_evt = comp_tick && at_crest;
	wire trough_evt = comp_tick && at_trough;
	wire do_xfer = transfer_armed &&
		((crest_evt && xfer_at_crest) || (trough_evt && xfer_at_trough));
	wire reverse = at_crest || at_trough;
	wire next_down = reverse ? !count_down : count_down;

	// normal mode clearing, only on an a-match when selected
	wire [2:0] clr3 = ch3_count_control[cpwm_pkg::CLR_LSB +: 3];
	wire [2:0] clr4 = ch4_count_control[cpwm_pkg::CLR_LSB +: 3];
	wire clear3 = clr3 == cpwm_pkg::CLR_ON_A &&
		ch3_counter == ch3_general_a;
	wire clear4 = clr4 == cpwm_pkg::CLR_ON_A &&
		ch4_counter == ch4_general_a;
	wire match_a3 = comp_mode ? crest_evt :
		(tick[0] && ch3_counter == ch3_general_a);

	// next counter values; software writes win over counting
	wire [15:0] step3 = next_down ? ch3_counter - cpwm_pkg::COUNT_STEP :
		ch3_counter + cpwm_pkg::COUNT_STEP;
	wire [15:0] step4 = next_down ? ch4_counter - cpwm_pkg::COUNT_STEP :
		ch4_counter + cpwm_pkg::COUNT_STEP;
	wire [15:0] next_ch3_counter = w_cnt3 ? wd :
		comp_tick ? step3 :
		(!comp_mode && tick[0]) ?
		(clear3 ? cpwm_pkg::REG16_RESET :
		ch3_counter + cpwm_pkg::COUNT_STEP) : ch3_counter;
	wire [15:0] next_ch4_counter = w_cnt4 ? wd :
		comp_tick ? step4 :
		(!comp_mode && tick[1]) ?
		(clear4 ? cpwm_pkg::REG16_RESET :
		ch4_counter + cpwm_pkg::COUNT_STEP) : ch4_counter;

	// counters and direction
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ch3_counter <= cpwm_pkg::REG16_RESET;
			ch4_counter <= cpwm_pkg::REG16_RESET;
			count_down <= 1'b0;
		end else begin
			ch3_counter <= next_ch3_counter;
			ch4_counter <= next_ch4_counter;
			if (!comp_run) begin
				count_down <= 1'b0;
			end else if (comp_tick) begin
				count_down <= next_down;
			end
		end
	end

	// buffered compare registers, loaded by software or by transfer
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ch3_general_a <= cpwm_pkg::REG16_RESET;
			ch3_general_b <= cpwm_pkg::REG16_RESET;
			ch4_general_a <= cpwm_pkg::REG16_RESET;
			ch4_general_b <= cpwm_pkg::REG16_RESET;
			half_period <= cpwm_pkg::REG16_RESET;
		end else begin
			if (w_ga3) begin
				ch3_general_a <= wd;
			end else if (do_xfer && ch3_mode[cpwm_pkg::BUF_A_BIT]) begin
				ch3_general_a <= ch3_general_c;
			end
			if (w_gb3) begin
				ch3_general_b <= wd;
			end else if (do_xfer && ch3_mode[cpwm_pkg::BUF_B_BIT]) begin
				ch3_general_b <= ch3_general_d;
			end
			if (w_ga4) begin
				ch4_general_a <= wd;
			end else if (do_xfer && ch3_mode[cpwm_pkg::BUF_A_BIT]) begin
				ch4_general_a <= ch4_general_c;
			end
			if (w_gb4) begin
				ch4_general_b <= wd;
			end else if (do_xfer && ch3_mode[cpwm_pkg::BUF_B_BIT]) begin
				ch4_general_b <= ch4_general_d;
			end
			if (w_hp) begin
				half_period <= wd;
			end else if (do_xfer) begin
				half_period <= half_period_buffer;
			end
		end
	end

	// transfer waits for ch4 general d; a new write beats the clear
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			transfer_armed <= 1'b0;
		end else if (w_gd4) begin
			transfer_armed <= 1'b1;
		end else if (do_xfer) begin
			transfer_armed <= 1'b0;
		end
	end

	// plain software registers
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			ch3_count_control <= cpwm_pkg::REG8_RESET;
			ch4_count_control <= cpwm_pkg::REG8_RESET;
			ch3_mode <= cpwm_pkg::REG8_RESET;
			ch4_mode <= cpwm_pkg::REG8_RESET;
			ch3_irq_enable <= cpwm_pkg::REG8_RESET;
			output_master_enable <= cpwm_pkg::REG8_RESET;
			counter_start <= cpwm_pkg::REG8_RESET;
			dead_time <= cpwm_pkg::REG16_RESET;
			half_period_buffer <= cpwm_pkg::REG16_RESET;
			ch3_general_c <= cpwm_pkg::REG16_RESET;
			ch3_general_d <= cpwm_pkg::REG16_RESET;
			ch4_general_c <= cpwm_pkg::REG16_RESET;
			ch4_general_d <= cpwm_pkg::REG16_RESET;
		end else begin
			if (w_cc3) ch3_count_control <= wd[7:0];
			if (w_cc4) ch4_count_control <= wd[7:0];
			if (w_md3) ch3_mode <= wd[7:0];
			if (w_md4) ch4_mode <= wd[7:0];
			if (w_ie3) ch3_irq_enable <= wd[7:0];
			if (w_oe) output_master_enable <= wd[7:0];
			if (w_start) counter_start <= wd[7:0];
			if (w_dt) dead_time <= wd;
			if (w_hpb) half_period_buffer <= wd;
			if (w_gc3) ch3_general_c <= wd;
			if (w_gd3) ch3_general_d <= wd;
			if (w_gc4) ch4_general_c <= wd;
			if (w_gd4) ch4_general_d <= wd;
		end
	end

	// output control; lock sticks until reset and freezes level bits
	wire locked = output_control_1[cpwm_pkg::LOCK_BIT];
	wire [7:0] oc1_keep = 8'h07;
	wire [7:0] next_oc1 = locked ?
		((wd[7:0] & ~oc1_keep) | (output_control_1 & oc1_keep) |
		(8'h08)) : wd[7:0];
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			output_control_1 <= cpwm_pkg::REG8_RESET;
			output_control_2 <= cpwm_pkg::REG8_RESET;
		end else begin
			if (w_oc1) output_control_1 <= next_oc1;
			if (w_oc2 && !locked) output_control_2 <= wd[7:0];
		end
	end

	// compare a flag: set wins over a software clear
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			compare_a_flag <= 1'b0;
		end else if (match_a3) begin
			compare_a_flag <= 1'b1;
		end else if (w_st && !wd[cpwm_pkg::FLAG_A_BIT]) begin
			compare_a_flag <= 1'b0;
		end
	end
	assign irq = compare_a_flag &&
		ch3_irq_enable[cpwm_pkg::IRQ_A_BIT];

	// level source and active levels
	wire [7:0] oc_src = output_control_1[cpwm_pkg::SRC_BIT] ?
		output_control_2 : output_control_1;
	wire pos_act = oc_src[cpwm_pkg::POS_LEVEL_BIT];
	wire inv_act = oc_src[cpwm_pkg::INV_LEVEL_BIT];

	// on states: pos on past ch4, inv on below ch3, offset is dead time
	wire p1_on = ch4_counter > ch3_general_b || ~|ch3_general_b;
	wire p2_on = ch4_counter > ch4_general_a || ~|ch4_general_a;
	wire p3_on = ch4_counter > ch4_general_b || ~|ch4_general_b;
	wire n1_on = ch3_counter < ch3_general_b;
	wire n2_on = ch3_counter < ch4_general_a;
	wire n3_on = ch3_counter < ch4_general_b;
	cpwm_pkg::cpwm_pins_type next_pin_level;
	assign next_pin_level.pwm1_pos_pin = comp_run && p1_on ? pos_act : !pos_act;
	assign next_pin_level.pwm2_pos_pin = comp_run && p2_on ? pos_act : !pos_act;
	assign next_pin_level.pwm3_pos_pin = comp_run && p3_on ? pos_act : !pos_act;
	assign next_pin_level.pwm1_inv_pin = comp_run && n1_on ? inv_act : !inv_act;
	assign next_pin_level.pwm2_inv_pin = comp_run && n2_on ? inv_act : !inv_act;
	assign next_pin_level.pwm3_inv_pin = comp_run && n3_on ? inv_act : !inv_act;

	// pin levels follow compare results; toggle pin flips at crest and trough
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			pin_level <= '1;
			carrier_toggle_pin <= 1'b1;
		end else begin
			pin_level <= next_pin_level;
			if ((crest_evt || trough_evt) &&
				output_control_1[cpwm_pkg::TOGGLE_BIT]) begin
				carrier_toggle_pin <= !carrier_toggle_pin;
			end
		end
	end
	assign pwm_pins = pin_level;

	// master enables gate each pin driver
	assign pwm_oe.pwm1_pos_pin = output_master_enable[cpwm_pkg::OE_P1];
	assign pwm_oe.pwm2_pos_pin = output_master_enable[cpwm_pkg::OE_P2];
	assign pwm_oe.pwm3_pos_pin = output_master_enable[cpwm_pkg::OE_P3];
	assign pwm_oe.pwm1_inv_pin = output_master_enable[cpwm_pkg::OE_N1];
	assign pwm_oe.pwm2_inv_pin = output_master_enable[cpwm_pkg::OE_N2];
	assign pwm_oe.pwm3_inv_pin = output_master_enable[cpwm_pkg::OE_N3];

	// read selection, unmapped addresses read zero
	wire [31:0] ra = bus_req.addr;
	wire [15:0] next_rdata =
		ra == cpwm_pkg::ch3_count_control_addr ? {8'h00, ch3_count_control} :
		ra == cpwm_pkg::ch4_count_control_addr ? {8'h00, ch4_count_control} :
		ra == cpwm_pkg::ch3_mode_addr ? {8'h00, ch3_mode} :
		ra == cpwm_pkg::ch4_mode_addr ? {8'h00, ch4_mode} :
		ra == cpwm_pkg::ch3_irq_enable_addr ? {8'h00, ch3_irq_enable} :
		ra == cpwm_pkg::output_master_enable_addr ?
		{8'h00, output_master_enable} :
		ra == cpwm_pkg::output_control_1_addr ? {8'h00, output_control_1} :
		ra == cpwm_pkg::output_control_2_addr ? {8'h00, output_control_2} :
		ra == cpwm_pkg::ch3_counter_addr ? ch3_counter :
		ra == cpwm_pkg::ch4_counter_addr ? ch4_counter :
		ra == cpwm_pkg::half_period_addr ? half_period :
		ra == cpwm_pkg::dead_time_addr ? dead_time :
		ra == cpwm_pkg::ch3_general_a_addr ? ch3_general_a :
		ra == cpwm_pkg::ch3_general_b_addr ? ch3_general_b :
		ra == cpwm_pkg::ch4_general_a_addr ? ch4_general_a :
		ra == cpwm_pkg::ch4_general_b_addr ? ch4_general_b :
		ra == cpwm_pkg::half_period_buffer_addr ? half_period_buffer :
		ra == cpwm_pkg::ch3_general_c_addr ? ch3_general_c :
		ra == cpwm_pkg::ch3_general_d_addr ? ch3_general_d :
		ra == cpwm_pkg::ch4_general_c_addr ? ch4_general_c :
		ra == cpwm_pkg::ch4_general_d_addr ? ch4_general_d :
		ra == cpwm_pkg::ch3_status_addr ? {15'h0000, compare_a_flag} :
		ra == cpwm_pkg::counter_start_addr ? {8'h00, counter_start} :
		cpwm_pkg::REG16_RESET;

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			rdata <= cpwm_pkg::REG16_RESET;
		end else if (bus_req.rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= cpwm_pkg::REG16_RESET;
		end
	end

endmodule

/* File: logic/cpwm_pkg.sv */
// package for the complementary pwm timer: register map, fields, carriers
// assumes a single 20 MHz clock and a plain strobe register port
package cpwm_pkg;

	localparam int ADDR_W = 32;
	localparam int DATA_W = 16;

	// register request from the software port
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} cpwm_bus_req_type;

	// six bridge pins, one bit each
	typedef struct packed {
		logic pwm3_inv_pin;
		logic pwm2_inv_pin;
		logic pwm1_inv_pin;
		logic pwm3_pos_pin;
		logic pwm2_pos_pin;
		logic pwm1_pos_pin;
	} cpwm_pins_type;

	// register byte addresses
	localparam logic [31:0] ch3_count_control_addr = 32'hfffe_4200;
	localparam logic [31:0] ch4_count_control_addr = 32'hfffe_4201;
	localparam logic [31:0] ch3_mode_addr = 32'hfffe_4202;
	localparam logic [31:0] ch4_mode_addr = 32'hfffe_4203;
	localparam logic [31:0] ch3_irq_enable_addr = 32'hfffe_4208;
	localparam logic [31:0] output_master_enable_addr = 32'hfffe_420a;
	localparam logic [31:0] output_control_1_addr = 32'hfffe_420e;
	localparam logic [31:0] output_control_2_addr = 32'hfffe_420f;
	localparam logic [31:0] ch3_counter_addr = 32'hfffe_4210;
	localparam logic [31:0] ch4_counter_addr = 32'hfffe_4212;
	localparam logic [31:0] half_period_addr = 32'hfffe_4214;
	localparam logic [31:0] dead_time_addr = 32'hfffe_4216;
	localparam logic [31:0] ch3_general_a_addr = 32'hfffe_4218;
	localparam logic [31:0] ch3_general_b_addr = 32'hfffe_421a;
	localparam logic [31:0] ch4_general_a_addr = 32'hfffe_421c;
	localparam logic [31:0] ch4_general_b_addr = 32'hfffe_421e;
	localparam logic [31:0] half_period_buffer_addr = 32'hfffe_4222;
	localparam logic [31:0] ch3_general_c_addr = 32'hfffe_4224;
	localparam logic [31:0] ch3_general_d_addr = 32'hfffe_4226;
	localparam logic [31:0] ch4_general_c_addr = 32'hfffe_4228;
	localparam logic [31:0] ch4_general_d_addr = 32'hfffe_422a;
	localparam logic [31:0] ch3_status_addr = 32'hfffe_422c;
	localparam logic [31:0] counter_start_addr = 32'hffff_4280;

	// count control fields
	localparam int CLR_LSB = 5;
	localparam int EDGE_LSB = 3;
	localparam int PSC_LSB = 0;
	localparam logic [2:0] CLR_NONE = 3'h0;
	localparam logic [2:0] CLR_ON_A = 3'h1;
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [2:0] PSC_DIV1 = 3'h0;
	localparam logic [2:0] PSC_DIV4 = 3'h1;
	localparam logic [2:0] PSC_DIV16 = 3'h2;
	localparam logic [2:0] PSC_DIV64 = 3'h3;
	localparam logic [5:0] DIV1_LAST = 6'h00;
	localparam logic [5:0] DIV4_LAST = 6'h03;
	localparam logic [5:0] DIV16_LAST = 6'h0f;
	localparam logic [5:0] DIV64_LAST = 6'h3f;

	// mode fields
	localparam int BUF_B_BIT = 5;
	localparam int BUF_A_BIT = 4;
	localparam logic [3:0] MODE_COMP_CREST = 4'hd;
	localparam logic [3:0] MODE_COMP_TROUGH = 4'he;
	localparam logic [3:0] MODE_COMP_BOTH = 4'hf;

	// output control fields
	localparam int TOGGLE_BIT = 6;
	localparam int LOCK_BIT = 3;
	localparam int SRC_BIT = 2;
	localparam int INV_LEVEL_BIT = 1;
	localparam int POS_LEVEL_BIT = 0;

	// start, irq enable, status bits
	localparam int START3_BIT = 6;
	localparam int START4_BIT = 7;
	localparam int IRQ_A_BIT = 0;
	localparam int FLAG_A_BIT = 0;

	// master enable bit positions
	localparam int OE_P1 = 0;
	localparam int OE_P2 = 1;
	localparam int OE_P3 = 2;
	localparam int OE_N1 = 3;
	localparam int OE_N2 = 4;
	localparam int OE_N3 = 5;

	localparam logic [7:0] REG8_RESET = 8'h00;
	localparam logic [15:0] REG16_RESET = 16'h0000;
	localparam logic [15:0] COUNT_STEP = 16'h0001;

endpackage

/* File: test/cpwm_monitor.sv */
// port checker for the complementary pwm timer, bound to cpwm_timer
// assumes the bench keeps active-low levels, and prescale by four in comp mode
module cpwm_monitor (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire cpwm_pkg::cpwm_bus_req_type bus_req,
	input wire logic [cpwm_pkg::DATA_W-1:0] rdata,
	input wire logic irq,
	input wire cpwm_pkg::cpwm_pins_type pwm_pins,
	input wire cpwm_pkg::cpwm_pins_type pwm_oe,
	input wire logic carrier_toggle_pin
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	logic run_seen;
	logic start_wr;
	// a start write marks the end of the idle phase
	assign start_wr = bus_req.wr && bus_req.addr == cpwm_pkg::counter_start_addr;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn)
			run_seen <= 1'b0;
		else if (start_wr && bus_req.wdata[7:6] != 2'h0)
			run_seen <= 1'b1;
	end
	rdata_idle_a: assert property (!$past(bus_req.rd) |-> rdata == 16'h0000)
		else $error("read data outside answer cycle");
	oe_match_a: assert property (bus_req.wr &&
		bus_req.addr == cpwm_pkg::output_master_enable_addr
		|=> pwm_oe == $past(bus_req.wdata[5:0])) else $error("enable bits wrong");
	oe_hold_a: assert property (!$past(bus_req.wr) |-> $stable(pwm_oe))
		else $error("enable changed without write");
	idle_pins_a: assert property (!run_seen |->
		pwm_pins == 6'h3f && carrier_toggle_pin) else $error("pins not idle");
	pin_spacing_a: assert property ($changed(pwm_pins.pwm1_pos_pin) |=>
		$stable(pwm_pins.pwm1_pos_pin) [*3]) else $error("pin changed too soon");
	toggle_spacing_a: assert property ($changed(carrier_toggle_pin) |=>
		$stable(carrier_toggle_pin) [*8]) else $error("toggle too fast");
	crest_toggle_a: assert property ($rose(irq) |->
		##[0:1] $changed(carrier_toggle_pin)) else $error("no toggle at crest");
	irq_mask_a: assert property (bus_req.wr && !bus_req.wdata[0] &&
		bus_req.addr == cpwm_pkg::ch3_irq_enable_addr |=> !irq)
		else $error("irq not masked");
	irq_cover_c: cover property ($rose(irq));
	toggle_cover_c: cover property ($changed(carrier_toggle_pin));
	read_cover_c: cover property (bus_req.rd ##1 rdata != 16'h0000);
endmodule
bind cpwm_timer cpwm_monitor mon (.clk_sys(clk_sys), .rstn(rstn),
	.bus_req(bus_req), .rdata(rdata), .irq(irq), .pwm_pins(pwm_pins),
	.pwm_oe(pwm_oe), .carrier_toggle_pin(carrier_toggle_pin));

/* File: test/cpwm_bridge_model.sv */
// gate driver model of the inverter bridge: counts shoot-through cycles
// assumes gate inputs pulled up (off) when the timer does not drive them
module cpwm_bridge_model (
	input wire logic clk_sys,
	input wire cpwm_pkg::cpwm_pins_type pwm_pins,
	input wire cpwm_pkg::cpwm_pins_type pwm_oe,
	output int overlap
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [5:0] gate;
	// undriven pins float to the pull-up level
	assign gate = pwm_oe & pwm_pins | ~pwm_oe;
	initial overlap = 0;
	// low is on: both gates of one leg on is a short
	always @(posedge clk_sys) begin
		overlap += int'(!gate[0] && !gate[3]) + int'(!gate[1] && !gate[4]);
		overlap += int'(!gate[2] && !gate[5]);
	end
endmodule

/* File: test/testbench.sv */
// self-checking bench for the complementary pwm timer
// assumes the register port answers reads one cycle later
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin fails++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, x); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic [31:0] a; logic [15:0] d; logic [15:0] e;} cpwm_row_type;
	logic clk_sys;
	logic rstn;
	cpwm_pkg::cpwm_bus_req_type bus_req;
	logic [15:0] rdata;
	logic irq;
	logic carrier_toggle_pin;
	logic p1;
	logic [15:0] v;
	logic [15:0] w;
	cpwm_pkg::cpwm_pins_type pwm_pins;
	cpwm_pkg::cpwm_pins_type pwm_oe;
	int fails = 0;
	int cmp_count = 0;
	int overlap;
	int hi;
	int bad;
	int chg;
	// register rows and one unmapped address: address, write data, expected read back
	cpwm_row_type rows[21] = '{
		'{cpwm_pkg::ch3_count_control_addr, 16'h0001, 16'h0001},
		'{cpwm_pkg::ch4_count_control_addr, 16'h0001, 16'h0001},
		'{cpwm_pkg::ch3_mode_addr, 16'h003f, 16'h003f},
		'{cpwm_pkg::ch4_mode_addr, 16'h0002, 16'h0002},
		'{cpwm_pkg::ch3_irq_enable_addr, 16'h0001, 16'h0001},
		'{cpwm_pkg::output_control_1_addr, 16'h0040, 16'h0040},
		'{cpwm_pkg::dead_time_addr, 16'h0002, 16'h0002},
		'{cpwm_pkg::ch3_counter_addr, 16'h0002, 16'h0002},
		'{cpwm_pkg::ch4_counter_addr, 16'h0000, 16'h0000},
		'{cpwm_pkg::ch3_general_a_addr, 16'h000c, 16'h000c},
		'{cpwm_pkg::ch3_general_c_addr, 16'h000c, 16'h000c},
		'{cpwm_pkg::half_period_addr, 16'h000a, 16'h000a},
		'{cpwm_pkg::half_period_buffer_addr, 16'h000a, 16'h000a},
		'{cpwm_pkg::ch3_general_b_addr, 16'h0006, 16'h0006},
		'{cpwm_pkg::ch3_general_d_addr, 16'h0006, 16'h0006},
		'{cpwm_pkg::ch4_general_a_addr, 16'h0000, 16'h0000},
		'{cpwm_pkg::ch4_general_c_addr, 16'h0000, 16'h0000},
		'{cpwm_pkg::ch4_general_b_addr, 16'h0009, 16'h0009},
		'{cpwm_pkg::ch4_general_d_addr, 16'h0009, 16'h0009},
		'{cpwm_pkg::output_master_enable_addr, 16'h003f, 16'h003f},
		'{32'hfffe_4204, 16'h0055, 16'h0000}};
	cpwm_timer uut (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
		.rdata(rdata), .irq(irq), .pwm_pins(pwm_pins), .pwm_oe(pwm_oe),
		.carrier_toggle_pin(carrier_toggle_pin));
	cpwm_bridge_model bridge (.clk_sys(clk_sys), .pwm_pins(pwm_pins),
		.pwm_oe(pwm_oe), .overlap(overlap));
	always #25 clk_sys = ~clk_sys;
	// one write cycle, settled at the following falling edge
	task automatic wr(input logic [31:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		@(negedge clk_sys);
	endtask
	// one read cycle, data taken in the answer cycle
	task automatic rd(input logic [31:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		@(negedge clk_sys);
		d = rdata;
	endtask
	task automatic chk_reset();
		`CHK(pwm_pins, 6'h3f)
		`CHK(pwm_oe, 6'h00)
		`CHK(carrier_toggle_pin, 1'b1)
		`CHK(irq, 1'b0)
	endtask
	task automatic wait_irq();
		for (int k = 0; k < 200 && irq !== 1'b1; k++)
			@(negedge clk_sys);
		`CHK(irq, 1'b1)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#(5000 * 50);
		fails++;
		tally_and_finish();
	end
	initial begin
		clk_sys = 1'b0;
		rstn = 1'b0;
		bus_req = '0;
		repeat (5) @(posedge clk_sys);
		chk_reset();
		rstn <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, v);
			`CHK(v, rows[i].e)
		end
		`CHK(pwm_oe, 6'h3f)
		wr(cpwm_pkg::counter_start_addr, 16'h00c0);
		rd(cpwm_pkg::ch3_counter_addr, v);
		repeat (2) @(posedge clk_sys);
		rd(cpwm_pkg::ch3_counter_addr, w);
		`CHK(w, v + 16'h0001)
		wait_irq();
		`CHK(carrier_toggle_pin, 1'b0)
		rd(cpwm_pkg::ch3_status_addr, v);
		`CHK(v, 16'h0001)
		wr(cpwm_pkg::ch3_status_addr, 16'h0000);
		`CHK(irq, 1'b0)
		wr(cpwm_pkg::ch3_general_d_addr, 16'h0004);
		rd(cpwm_pkg::ch3_general_b_addr, v);
		`CHK(v, 16'h0006)
		wr(cpwm_pkg::ch4_general_d_addr, 16'h0009);
		wr(cpwm_pkg::ch3_irq_enable_addr, 16'h0000);
		hi = 0;
		bad = 0;
		chg = 0;
		p1 = pwm_pins.pwm1_pos_pin;
		// one full carrier with the interrupt masked
		repeat (100) begin
			@(negedge clk_sys);
			hi += int'(irq !== 1'b0);
			bad += int'(pwm_pins.pwm2_pos_pin !== 1'b0);
			bad += int'(pwm_pins.pwm2_inv_pin !== 1'b1);
			chg += int'(pwm_pins.pwm1_pos_pin !== p1);
			p1 = pwm_pins.pwm1_pos_pin;
		end
		`CHK(hi, 0)
		`CHK(bad, 0)
		`CHK(chg > 0, 1'b1)
		`CHK(overlap, 0)
		rd(cpwm_pkg::ch3_general_b_addr, v);
		`CHK(v, 16'h0004)
		rd(cpwm_pkg::ch3_status_addr, v);
		`CHK(v, 16'h0001)
		wr(cpwm_pkg::output_control_1_addr, 16'h0048);
		wr(cpwm_pkg::output_control_1_addr, 16'h0041);
		rd(cpwm_pkg::output_control_1_addr, v);
		`CHK(v, 16'h0048)
		wr(cpwm_pkg::output_master_enable_addr, 16'h0009);
		`CHK(pwm_oe, 6'h09)
		// second reset in mid-run
		@(posedge clk_sys);
		rstn <= 1'b0;
		repeat (2) @(negedge clk_sys);
		chk_reset();
		@(posedge clk_sys);
		rstn <= 1'b1;
		rd(cpwm_pkg::ch3_counter_addr, v);
		repeat (2) @(posedge clk_sys);
		rd(cpwm_pkg::ch3_counter_addr, w);
		`CHK(v, 16'h0000)
		`CHK(w, 16'h0000)
		rd(cpwm_pkg::output_control_1_addr, v);
		`CHK(v, 16'h0000)
		// normal mode: ch3 alone, no prescale, cleared on an a-match
		wr(cpwm_pkg::ch3_count_control_addr, 16'h0020);
		wr(cpwm_pkg::ch3_general_a_addr, 16'h0003);
		wr(cpwm_pkg::counter_start_addr, 16'h0040);
		repeat (20) @(posedge clk_sys);
		rd(cpwm_pkg::ch3_counter_addr, v);
		`CHK(v <= 16'h0003, 1'b1)
		rd(cpwm_pkg::ch3_status_addr, v);
		`CHK(v, 16'h0001)
		tally_and_finish();
	end
endmodule
